// file: logic/mmg_top.sv
// Behaviour
// - After any reset message interrupts are off and nothing is sent.
// - Control bit 0 enables messages and silences the legacy pin; resets zero.
// - Control bit 7 reads one: 64-bit message address capable.
// - Control bits 3:1 read 001: two messages requested at most.
// - Software writes granted count in bits 6:4, reset 000; one or two work.
// - Software programs dword-aligned address; every message write uses it.
// - Nonzero upper address makes the write a dual address cycle.
// - Two granted: post queue alone on one, doorbell and message on other.
// - One granted: every outbound source shares the single message.
// - Data phase carries message data on 15:0, bit 0 the vector if two granted, zeros on 31:16.
// - All four byte enables asserted during the data phase.
// - Extended table capability identifier reads 0DH.
// - Message interrupt capability identifier reads 05H.
`timescale 1ns/1ps
`default_nettype none
module mmg_top
  import mmg_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rdata_valid,
  input  wire logic        post_queue_event,
  input  wire logic        doorbell_event,
  input  wire logic        message_event,
  input  wire logic        outbound_irq_level,
  output logic             legacy_irq_pin_n,
  output logic             wr_req,
  output logic             wr_dac,
  output logic [63:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_cbe_n,
  input  wire logic        wr_ack
);
  import mmg_pkg::*;

  logic        msi_enable;
  logic [2:0]  mme;
  logic [31:0] msg_addr;
  logic [31:0] msg_upper;
  logic [15:0] msg_data;
  logic [1:0]  pending;
  logic [1:0]  next_pending;
  logic [1:0]  raise;
  logic [1:0]  clear;
  logic        multi;
  logic        busy;
  logic        cur_vec;
  logic [15:0] ctrl_value;

  mmg_msg_if msg ();

  assign multi = (mme != CTRL_MME_ONE);

  // read-only fields sit beside the writable ones.
  always_comb begin
    ctrl_value                 = 16'h0;
    ctrl_value[CTRL_ENABLE_BIT] = msi_enable;
    ctrl_value[3:1]            = CTRL_MMC_VALUE;
    ctrl_value[6:4]            = mme;
    ctrl_value[CTRL_CAP64_BIT] = 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msi_enable <= 1'b0;
      mme        <= CTRL_MME_RESET;
    end else if (cfg_wr && cfg_addr == MSI_CAP_OFFSET && cfg_be[2]) begin
      msi_enable <= cfg_wdata[16 + CTRL_ENABLE_BIT];
      mme        <= cfg_wdata[16 + CTRL_MME_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_addr <= 32'h0;
    end else if (cfg_wr && cfg_addr == MSI_ADDR_OFFSET) begin
      // The two low bits stay zero so the target is always dword aligned.
      if (cfg_be[0]) begin
        msg_addr[7:2] <= cfg_wdata[7:2];
      end
      if (cfg_be[1]) begin
        msg_addr[15:8] <= cfg_wdata[15:8];
      end
      if (cfg_be[2]) begin
        msg_addr[23:16] <= cfg_wdata[23:16];
      end
      if (cfg_be[3]) begin
        msg_addr[31:24] <= cfg_wdata[31:24];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_upper <= 32'h0;
    end else if (cfg_wr && cfg_addr == MSI_UPPER_OFFSET) begin
      if (cfg_be[0]) begin
        msg_upper[7:0] <= cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        msg_upper[15:8] <= cfg_wdata[15:8];
      end
      if (cfg_be[2]) begin
        msg_upper[23:16] <= cfg_wdata[23:16];
      end
      if (cfg_be[3]) begin
        msg_upper[31:24] <= cfg_wdata[31:24];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msg_data <= 16'h0;
    end else if (cfg_wr && cfg_addr == MSI_DATA_OFFSET) begin
      if (cfg_be[0]) begin
        msg_data[7:0] <= cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        msg_data[15:8] <= cfg_wdata[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata       <= 32'h0;
      cfg_rdata_valid <= 1'b0;
    end else begin
      cfg_rdata_valid <= cfg_rd;
      if (cfg_rd) begin
        if (cfg_addr == MSI_CAP_OFFSET) begin
          cfg_rdata <= {ctrl_value, MSI_NEXT_PTR, MSI_CAP_ID};
        end else if (cfg_addr == MSI_ADDR_OFFSET) begin
          cfg_rdata <= msg_addr;
        end else if (cfg_addr == MSI_UPPER_OFFSET) begin
          cfg_rdata <= msg_upper;
        end else if (cfg_addr == MSI_DATA_OFFSET) begin
          cfg_rdata <= {16'h0, msg_data};
        end else if (cfg_addr == XTAB_CAP_OFFSET) begin
          cfg_rdata <= {16'h0, XTAB_NEXT_PTR, XTAB_CAP_ID};
        end else begin
          cfg_rdata <= 32'h0;
        end
      end
    end
  end

  // Events are folded onto vectors; with one grant all of them share vector 0.
  always_comb begin
    raise    = 2'b00;
    raise[0] = post_queue_event | (~multi & (doorbell_event | message_event));
    raise[1] = multi & (doorbell_event | message_event);
    clear    = 2'b00;
    if (msg.send_done) begin
      clear[cur_vec] = 1'b1;
    end
    // A new event in the cycle its message completes stays pending.
    next_pending = (pending & ~clear) | raise;
  end

  // While disabled no event is recorded, so enabling later sends nothing stale.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pending <= 2'b00;
    end else if (!msi_enable) begin
      pending <= 2'b00;
    end else begin
      pending <= next_pending;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy         <= 1'b0;
      cur_vec      <= VEC_POST_QUEUE;
      msg.send_req <= 1'b0;
    end else begin
      msg.send_req <= 1'b0;
      if (msg.send_done) begin
        busy <= 1'b0;
      end else if (!busy && msi_enable && pending != 2'b00) begin
        busy         <= 1'b1;
        msg.send_req <= 1'b1;
        // The post queue vector wins when both wait.
        cur_vec      <= pending[0] ? VEC_POST_QUEUE : VEC_DOORBELL_MESSAGE;
      end
    end
  end

  assign msg.send_vec  = cur_vec;
  assign msg.multi     = multi;
  assign msg.msg_addr  = msg_addr;
  assign msg.msg_upper = msg_upper;
  assign msg.msg_data  = msg_data;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      legacy_irq_pin_n <= 1'b1;
    end else begin
      legacy_irq_pin_n <= ~(outbound_irq_level & ~msi_enable);
    end
  end

  mmg_msg_writer u_writer (
    .core_clk (core_clk),
    .rst      (rst),
    .msg      (msg),
    .wr_req   (wr_req),
    .wr_dac   (wr_dac),
    .wr_addr  (wr_addr),
    .wr_data  (wr_data),
    .wr_cbe_n (wr_cbe_n),
    .wr_ack   (wr_ack)
  );
endmodule
`default_nettype wire

// file: logic/mmg_pkg.sv
`default_nettype none
package mmg_pkg;
  // Configuration dword offsets of the capability structures.
  localparam logic [7:0] MSI_CAP_OFFSET        = 8'hA0;
  localparam logic [7:0] MSI_ADDR_OFFSET       = 8'hA4;
  localparam logic [7:0] MSI_UPPER_OFFSET      = 8'hA8;
  localparam logic [7:0] MSI_DATA_OFFSET       = 8'hAC;
  localparam logic [7:0] XTAB_CAP_OFFSET       = 8'hB0;

  localparam logic [7:0] MSI_CAP_ID            = 8'h05;
  localparam logic [7:0] MSI_NEXT_PTR          = 8'hB0;
  localparam logic [7:0] XTAB_CAP_ID           = 8'h0D;
  localparam logic [7:0] XTAB_NEXT_PTR         = 8'hE0;

  // Message control field positions and values.
  localparam int         CTRL_ENABLE_BIT       = 0;
  localparam int         CTRL_MME_LSB          = 4;
  localparam int         CTRL_CAP64_BIT        = 7;
  localparam logic [2:0] CTRL_MMC_VALUE        = 3'h1;
  localparam logic [2:0] CTRL_MME_RESET        = 3'h0;
  localparam logic [2:0] CTRL_MME_ONE          = 3'h0;

  localparam logic [3:0] DATA_PHASE_CBE_N      = 4'h0;

  // Vector numbers used with two granted messages.
  localparam logic       VEC_POST_QUEUE        = 1'b0;
  localparam logic       VEC_DOORBELL_MESSAGE  = 1'b1;

  typedef enum logic [1:0] {
    MMG_IDLE = 2'b01,
    MMG_REQ  = 2'b10
  } mmg_state_type;
endpackage
`default_nettype wire

// file: logic/mmg_msg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mmg_msg_if;
  logic        send_req;
  logic        send_vec;
  logic        send_done;
  logic        multi;
  logic [31:0] msg_addr;
  logic [31:0] msg_upper;
  logic [15:0] msg_data;

  modport ctrl (
    output send_req,
    output send_vec,
    output multi,
    output msg_addr,
    output msg_upper,
    output msg_data,
    input  send_done
  );
  modport writer (
    input  send_req,
    input  send_vec,
    input  multi,
    input  msg_addr,
    input  msg_upper,
    input  msg_data,
    output send_done
  );
endinterface
`default_nettype wire

// file: logic/mmg_msg_writer.sv
`timescale 1ns/1ps
`default_nettype none
module mmg_msg_writer
  import mmg_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   rst,
  mmg_msg_if.writer   msg,
  output logic        wr_req,
  output logic        wr_dac,
  output logic [63:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0]  wr_cbe_n,
  input  wire logic   wr_ack
);
  mmg_state_type state;
  logic [15:0]   next_data;

  always_comb begin
    next_data = msg.msg_data;
    if (msg.multi) begin
      next_data[0] = msg.send_vec;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state         <= MMG_IDLE;
      wr_req        <= 1'b0;
      wr_dac        <= 1'b0;
      wr_addr       <= 64'h0;
      wr_data       <= 32'h0;
      wr_cbe_n      <= 4'hF;
      msg.send_done <= 1'b0;
    end else begin
      msg.send_done <= 1'b0;
      case (state)
        MMG_IDLE: begin
          if (msg.send_req) begin
            state    <= MMG_REQ;
            wr_req   <= 1'b1;
            wr_dac   <= (msg.msg_upper != 32'h0);
            wr_addr  <= {msg.msg_upper, msg.msg_addr[31:2], 2'b00};
            wr_data  <= {16'h0, next_data};
            wr_cbe_n <= DATA_PHASE_CBE_N;
          end
        end
        MMG_REQ: begin
          if (wr_ack) begin
            state         <= MMG_IDLE;
            wr_req        <= 1'b0;
            wr_cbe_n      <= 4'hF;
            msg.send_done <= 1'b1;
          end
        end
        default: begin
          state  <= MMG_IDLE;
          wr_req <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: tb/mmg_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mmg_top_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        cfg_rd,
  input wire logic        cfg_rdata_valid,
  input wire logic        wr_req,
  input wire logic        wr_ack,
  input wire logic        wr_dac,
  input wire logic [63:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0]  wr_cbe_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ack;
    wr_req && wr_ack;
  endsequence
  sequence s_quiet;
    !wr_req [*2];
  endsequence
  property p_cbe; wr_req |-> wr_cbe_n == 4'h0; endproperty
  a_cbe: assert property (p_cbe) else $error("byte enables off in data phase");
  property p_high; wr_req |-> wr_data[31:16] == 16'h0; endproperty
  a_high: assert property (p_high) else $error("upper data lines not zero");
  property p_dac; wr_req |-> wr_dac == (wr_addr[63:32] != 32'h0); endproperty
  a_dac: assert property (p_dac) else $error("dual cycle flag mismatch");
  property p_align; wr_req |-> wr_addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("message address not aligned");
  property p_hold;
    wr_req && !wr_ack |=> wr_req && $stable(wr_addr) && $stable(wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("write dropped before ack");
  property p_ack; s_ack |=> s_quiet; endproperty
  a_ack: assert property (p_ack) else $error("request not released after ack");
  property p_rdv; cfg_rd |=> cfg_rdata_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("read answer missing");
  property p_rst; $fell(rst) |-> !wr_req; endproperty
  a_rst: assert property (p_rst) else $error("write pending out of reset");
endmodule
bind mmg_top mmg_top_properties u_props (.*);
`default_nettype wire

// file: tb/mmg_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmg_master_model (
  input wire logic        core_clk,
  input wire logic        wr_req,
  input wire logic [63:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_dac,
  input wire logic [3:0]  ack_delay,
  output logic            wr_ack,
  output logic [63:0]     got_addr,
  output logic [31:0]     got_data,
  output logic            got_dac,
  output int              msgs
);
  logic [3:0] wait_cnt;
  initial begin
    wr_ack = 1'b0;
    wait_cnt = 4'h0;
    msgs = 0;
  end
  // The write is captured at the edge that sees the ack, while the request still holds it.
  always @(posedge core_clk) begin
    if (wr_ack) begin
      wr_ack <= 1'b0;
      wait_cnt <= 4'h0;
      msgs <= msgs + 1;
      got_addr <= wr_addr;
      got_data <= wr_data;
      got_dac <= wr_dac;
    end else if (wr_req) begin
      if (wait_cnt == ack_delay)
        wr_ack <= 1'b1;
      else
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb/test_msi_message_generator.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module test_msi_message_generator;
  import mmg_pkg::*;
  logic        core_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, wr_data, got_data;
  logic [3:0]  cfg_be = 4'hF, wr_cbe_n, ack_delay = 4'h0;
  logic        post_queue_event = 0, doorbell_event = 0, message_event = 0;
  logic        outbound_irq_level = 0, legacy_irq_pin_n, cfg_rdata_valid;
  logic        wr_req, wr_dac, wr_ack, got_dac;
  logic [63:0] wr_addr, got_addr;
  int          msgs, fails = 0, cmp_count = 0;
  mmg_top dut (.*);
  mmg_master_model u_master (.*);
  always #2.5 core_clk = ~core_clk;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cfg_write(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
    @(negedge core_clk);
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(negedge core_clk);
    cfg_rd = 1'b0;
    `CHK(cfg_rdata_valid, 1'b1)
    `CHK(cfg_rdata, e)
  endtask
  // Bits of ev are post queue, doorbell, message; n is the number of writes expected.
  task automatic fire(input logic [2:0] ev, input int n, input logic [63:0] a,
                      input logic [31:0] d, input logic dac);
    int m0;
    int k;
    m0 = msgs;
    @(negedge core_clk);
    {post_queue_event, doorbell_event, message_event} = ev;
    @(negedge core_clk);
    {post_queue_event, doorbell_event, message_event} = 3'h0;
    for (k = 0; k < 60 && msgs < m0 + n; k++) @(negedge core_clk);
    if (k == 60) begin
      fails++;
      final_report();
    end
    repeat (4) @(negedge core_clk);
    `CHK(msgs, m0 + n)
    if (n > 0) begin
      `CHK(got_addr, a)
      `CHK(got_data, d)
      `CHK(got_dac, dac)
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    check_reg(8'hA0, 32'h0082B005);
    check_reg(8'hB0, 32'h0000E00D);
    check_reg(8'h10, 32'h00000000);
    outbound_irq_level = 1'b1;
    cfg_write(8'hA4, 32'h12345677);
    cfg_write(8'hAC, 32'h0000ABCD);
    fire(3'b100, 0, 64'h0, 32'h0, 1'b0);
    `CHK(legacy_irq_pin_n, 1'b0)
    $display("test done: reset and disabled");
    cfg_write(8'hA0, 32'h00010000);
    check_reg(8'hA4, 32'h12345674);
    `CHK(legacy_irq_pin_n, 1'b1)
    fire(3'b100, 1, 64'h12345674, 32'h0000ABCD, 1'b0);
    fire(3'b001, 1, 64'h12345674, 32'h0000ABCD, 1'b0);
    $display("test done: one message");
    ack_delay = 4'h5;
    cfg_write(8'hA0, 32'h00110000);
    check_reg(8'hA0, 32'h0093B005);
    cfg_write(8'hA8, 32'h00000001);
    fire(3'b100, 1, 64'h0000000112345674, 32'h0000ABCC, 1'b1);
    fire(3'b010, 1, 64'h0000000112345674, 32'h0000ABCD, 1'b1);
    fire(3'b101, 2, 64'h0000000112345674, 32'h0000ABCD, 1'b1);
    check_reg(8'hA8, 32'h00000001);
    // Byte lanes are written one at a time so that a lane mix-up shows.
    cfg_be = 4'h2;
    cfg_write(8'hAC, 32'hFFFF1200);
    cfg_be = 4'h1;
    cfg_write(8'hAC, 32'hFFFFFFCC);
    cfg_be = 4'hB;
    cfg_write(8'hA0, 32'h00000000);
    cfg_be = 4'hF;
    check_reg(8'hAC, 32'h000012CC);
    check_reg(8'hA0, 32'h0093B005);
    // With bit 0 of the data clear, only the vector can set it.
    fire(3'b010, 1, 64'h0000000112345674, 32'h000012CD, 1'b1);
    fire(3'b001, 1, 64'h0000000112345674, 32'h000012CD, 1'b1);
    fire(3'b100, 1, 64'h0000000112345674, 32'h000012CC, 1'b1);
    $display("test done: two messages");
    cfg_write(8'hA0, 32'h00000000);
    repeat (3) @(negedge core_clk);
    `CHK(legacy_irq_pin_n, 1'b0)
    $display("test done: disable again");
    cfg_write(8'hA0, 32'h00110000);
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(legacy_irq_pin_n, 1'b1)
    rst = 1'b0;
    check_reg(8'hA0, 32'h0082B005);
    check_reg(8'hA8, 32'h00000000);
    check_reg(8'hAC, 32'h00000000);
    fire(3'b111, 0, 64'h0, 32'h0, 1'b0);
    `CHK(legacy_irq_pin_n, 1'b0)
    $display("test done: reset in mid-run");
    final_report();
  end
endmodule
`default_nettype wire
